// ### verif/bors_sequencer_properties.sv
`timescale 1ns/100ps
`default_nettype none
module bors_sequencer_properties #(
  parameter int unsigned STARTUP_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic supply_above_trigger,
  input wire logic supply_above_threshold,
  input wire logic ext_reset_n,
  input wire bors_pkg::bors_status_t status,
  input wire logic [15:0] idle_count,
  input wire logic instruction_cycle
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  int unsigned up_q;
  // Cycles since trigger level rose
  always_ff @(posedge sys_clk) begin
    up_q <= supply_above_trigger ? up_q + 1 : 0;
  end
  sequence s_back;
    $rose(supply_above_threshold) && up_q > STARTUP_CYCLES + 4
      ##1 supply_above_threshold [*3];
  endsequence
  property p_drop;
    !supply_above_threshold [*3] |=> status.brownout_reset;
  endproperty
  a_drop: assert property (p_drop) else $error("no reset on drop");
  property p_pin;
    !ext_reset_n [*3] |=> status.core_reset;
  endproperty
  a_pin: assert property (p_pin) else $error("pin ignored");
  property p_same;
    status.brownout_reset |-> status.core_reset;
  endproperty
  a_same: assert property (p_same) else $error("core not reset");
  property p_underflow;
    $fell(status.brownout_reset) |-> $past(idle_count) == 16'h0000;
  endproperty
  a_underflow: assert property (p_underflow) else $error("early");
  property p_preset;
    !supply_above_threshold [*4] |-> idle_count[15:4] == 12'h00F;
  endproperty
  a_preset: assert property (p_preset) else $error("bad preset");
  property p_gate;
    !supply_above_threshold [*4] |-> !status.countdown_active;
  endproperty
  a_gate: assert property (p_gate) else $error("counts low");
  property p_delay;
    $rose(status.countdown_active) |-> up_q >= STARTUP_CYCLES;
  endproperty
  a_delay: assert property (p_delay) else $error("delay short");
  property p_back;
    s_back |-> status.countdown_active;
  endproperty
  a_back: assert property (p_back) else $error("late start");
  property p_hold;
    supply_above_threshold [*3] ##0 !status.brownout_reset
      |=> !status.brownout_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("extra reset");
endmodule
`default_nettype wire

// ### verif/bors_supply_model.sv
`timescale 1ns/100ps
`default_nettype none
module bors_supply_model (
  input wire logic [1:0] level,
  input wire logic pin_low,
  output bors_pkg::bors_supply_t sup
);
  // Level 0 off, 1 above trigger only, 2 above threshold
  assign sup = '{level != 2'h0, level == 2'h2, !pin_low};
endmodule
`default_nettype wire

// ### verif/test_bors_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module test_bors_sequencer;
  logic sys_clk = 1'b0, reset = 1'b1, pin_low = 1'b0, instruction_cycle;
  logic [1:0] level = 2'h0;
  logic [15:0] idle_count;
  bors_pkg::bors_supply_t sup;
  bors_pkg::bors_status_t status;
  int checks = 0, n_mismatch = 0, cyc = 0, i;
  always #5 sys_clk = ~sys_clk;
  bors_supply_model i_bors_supply_model (.level(level), .pin_low(pin_low),
    .sup(sup));
  bors_sequencer #(.STARTUP_CYCLES(20)) i_bors_sequencer (.sys_clk(sys_clk),
    .reset(reset), .supply_above_trigger(sup.above_trigger),
    .supply_above_threshold(sup.above_threshold),
    .ext_reset_n(sup.ext_reset_n), .status(status),
    .idle_count(idle_count), .instruction_cycle(instruction_cycle));
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic countdown_ok(input int n);
    countdown_ok = (n >= 240) && (n <= 256);
  endfunction
  // Kind 0 power-up, 1 shallow dip, 2 deep dip with slow rise
  task automatic dip(input int k);
    int d, t;
    level = (k == 1) ? 2'h1 : 2'h0;
    repeat (5 + $urandom_range(20)) @(negedge sys_clk);
    `CHK(status.brownout_reset, 1'b1)
    `CHK(idle_count[15:4], 12'h00F)
    if (k == 2) begin
      level = 2'h1;
      repeat (30) @(negedge sys_clk);
    end
    level = 2'h2;
    for (d = 0; !status.countdown_active && d < 99; d++) @(negedge sys_clk);
    `CHK(d >= 20, k == 0)
    t = 0;
    while (status.brownout_reset && cyc < 59000) begin
      @(negedge sys_clk);
      if (status.countdown_active && instruction_cycle) t++;
    end
    `CHK(countdown_ok(t), 1'b1)
    `CHK(status.core_reset, 1'b0)
    $display("dip kind %0d done", k);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  initial begin
    void'($urandom(32'h0149));
    repeat (12) @(negedge sys_clk);
    reset = 1'b0;
    for (i = 0; i < 5; i++) dip(i < 3 ? i : $urandom_range(2));
    pin_low = 1'b1;
    repeat (10) @(negedge sys_clk);
    `CHK(status.core_reset, 1'b1)
    `CHK(status.brownout_reset, 1'b0)
    pin_low = 1'b0;
    repeat (5) @(negedge sys_clk);
    `CHK(status.core_reset, 1'b0)
    $display("pin test done");
    end_of_test;
  end
endmodule
bind bors_sequencer bors_sequencer_properties #(
  .STARTUP_CYCLES(STARTUP_CYCLES)) i_bors_sequencer_properties (
  .sys_clk(sys_clk), .reset(reset), .ext_reset_n(ext_reset_n),
  .supply_above_trigger(supply_above_trigger), .status(status),
  .supply_above_threshold(supply_above_threshold),
  .idle_count(idle_count), .instruction_cycle(instruction_cycle));
`default_nettype wire

// ### verilog/bors_pkg.sv
// Operation
// RL1: Hold reset through about 3 ms delay after power-up or deep dip.
// RL2: Delay starts when supply passes trigger level, regardless of threshold.
// RL3: Starting the delay loads the idle timer with a value 0x00F0 to 0x00FF.
// RL4: Idle timer counts only when above threshold and delay is done.
// RL5: Once detector is alive, block holds device in reset.
// RL6: Supply falling below threshold asserts reset at once.
// RL7: Delay already done at threshold crossing: countdown starts right away.
// RL8: Shallow dip skips the delay; countdown starts on threshold return.
// RL9: Only idle timer underflow releases the brownout reset.
// RL10: Brownout reset acts exactly like the external reset.
// RL11: No further reset after release while supply stays above threshold.
// RL12: Each detector activation presets 240-256 cycle countdown, asserts reset.
// RL13: Reset does not initialize data registers or RAM.
// RL14: Device resets on external reset low or brownout reset active.
// RL15: External reset must be held low at least one instruction cycle.
// RL16: Supply flags synchronized; delay counter terminal count near 3 ms.
package bors_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned STARTUP_DELAY_TIME_US = 3000;
  localparam int unsigned STARTUP_CYCLES =
    (STARTUP_DELAY_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned DLY_W = 19;
  localparam logic [15:0] IDLE_PRESET = 16'h00F0;
  localparam logic [15:0] IDLE_PRESET_MAX = 16'h00FF;
  localparam int unsigned INSTR_DIV = 10;
  localparam logic [3:0] INSTR_DIV_LAST = 4'h9;

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_DELAY = 4'h2,
    ST_WAIT = 4'h4,
    ST_RUN = 4'h8
  } bors_state_t;

  typedef struct packed {
    logic above_trigger;
    logic above_threshold;
    logic ext_reset_n;
  } bors_supply_t;

  typedef struct packed {
    logic core_reset;
    logic brownout_reset;
    logic countdown_active;
  } bors_status_t;

endpackage

// ### verilog/bors_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module bors_sequencer #(
  parameter int unsigned STARTUP_CYCLES = bors_pkg::STARTUP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic supply_above_trigger,
  input wire logic supply_above_threshold,
  input wire logic ext_reset_n,
  output bors_pkg::bors_status_t status,
  output logic [15:0] idle_count,
  output logic instruction_cycle
);

  typedef struct packed {
    bors_pkg::bors_state_t fsm;
    logic delay_done;
    logic [bors_pkg::DLY_W-1:0] dly_cnt;
    logic [15:0] idle_cnt;
    logic [3:0] div_cnt;
    logic tick;
    logic [3:0] preset_lo;
    bors_pkg::bors_status_t stat;
  } bors_seq_state_t;

  bors_seq_state_t st_q;
  bors_seq_state_t st_d;
  bors_pkg::bors_supply_t sup_async;
  bors_pkg::bors_supply_t sup;
  logic [bors_pkg::DLY_W-1:0] dly_last;

  assign sup_async = '{above_trigger: supply_above_trigger,
                       above_threshold: supply_above_threshold,
                       ext_reset_n: ext_reset_n};
  assign dly_last = bors_pkg::DLY_W'(STARTUP_CYCLES - 1);

  bors_sync u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(sup_async),
    .sync_out(sup)
  );

  function automatic logic [15:0] idle_preset(input logic [3:0] lo);
    idle_preset = bors_pkg::IDLE_PRESET | {12'h000, lo};
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.div_cnt == bors_pkg::INSTR_DIV_LAST) begin
      st_d.div_cnt = 4'h0;
      st_d.tick = 1'b1;
    end else begin
      st_d.div_cnt = st_q.div_cnt + 4'h1;
    end
    // Free-running low nibble picks the preset within 00F0..00FF
    st_d.preset_lo = st_q.preset_lo + 4'h1;

    case (st_q.fsm)
      bors_pkg::ST_OFF: begin
        st_d.delay_done = 1'b0;
        st_d.dly_cnt = '0;
        if (sup.above_trigger) begin
          st_d.fsm = bors_pkg::ST_DELAY; // RL2
          st_d.idle_cnt = idle_preset(st_q.preset_lo); // RL3
        end
      end
      bors_pkg::ST_DELAY: begin
        if (!sup.above_trigger) begin
          st_d.fsm = bors_pkg::ST_OFF; // RL1
        end else if (st_q.dly_cnt == dly_last) begin
          st_d.delay_done = 1'b1; // RL16
          st_d.fsm = bors_pkg::ST_WAIT;
        end else begin
          st_d.dly_cnt = st_q.dly_cnt + {{(bors_pkg::DLY_W-1){1'b0}}, 1'b1};
        end
      end
      bors_pkg::ST_WAIT: begin
        if (!sup.above_trigger) begin
          st_d.fsm = bors_pkg::ST_OFF; // RL1
        end else if (!sup.above_threshold) begin
          st_d.idle_cnt = idle_preset(st_q.preset_lo); // RL12
        end else if (st_q.delay_done && st_q.tick) begin
          // RL4 RL7 RL8
          if (st_q.idle_cnt == 16'h0000) begin
            st_d.fsm = bors_pkg::ST_RUN; // RL9
          end else begin
            st_d.idle_cnt = st_q.idle_cnt - 16'h0001;
          end
        end
      end
      bors_pkg::ST_RUN: begin
        if (!sup.above_trigger) begin
          st_d.fsm = bors_pkg::ST_OFF; // RL1
        end else if (!sup.above_threshold) begin
          st_d.fsm = bors_pkg::ST_WAIT; // RL6 RL8
          st_d.idle_cnt = idle_preset(st_q.preset_lo); // RL12
        end
      end
      default: begin
        st_d.fsm = bors_pkg::ST_OFF;
      end
    endcase

    // Preset held while below threshold, also on a deep drop to off
    if (!sup.above_threshold) begin
      st_d.idle_cnt = idle_preset(st_q.preset_lo); // RL12
    end

    // Brownout reset held in every state but run; RL11 follows from ST_RUN
    st_d.stat.brownout_reset = (st_d.fsm != bors_pkg::ST_RUN); // RL5 RL6 RL9
    st_d.stat.countdown_active = (st_d.fsm == bors_pkg::ST_WAIT) &&
      st_d.delay_done && sup.above_threshold;
    // Same core reset for both sources; no data storage is cleared here
    st_d.stat.core_reset = st_d.stat.brownout_reset ||
      !sup.ext_reset_n; // RL10 RL14 RL13 RL15
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q.fsm <= bors_pkg::ST_OFF;
      st_q.delay_done <= 1'b0;
      st_q.dly_cnt <= '0;
      st_q.idle_cnt <= bors_pkg::IDLE_PRESET_MAX;
      st_q.div_cnt <= 4'h0;
      st_q.tick <= 1'b0;
      st_q.preset_lo <= 4'h0;
      st_q.stat <= 3'b110;
    end else begin
      st_q <= st_d;
    end
  end

  assign status = st_q.stat;
  assign idle_count = st_q.idle_cnt;
  assign instruction_cycle = st_q.tick;

endmodule
`default_nettype wire

// ### verilog/bors_sync.sv
`timescale 1ns/100ps
`default_nettype none
module bors_sync (
  input wire logic sys_clk,
  input wire logic reset,
  input wire bors_pkg::bors_supply_t async_in,
  output bors_pkg::bors_supply_t sync_out
);

  typedef struct packed {
    bors_pkg::bors_supply_t meta;
    bors_pkg::bors_supply_t stable;
  } bors_sync_state_t;

  bors_sync_state_t st_q;
  bors_sync_state_t st_d;

  // Two flops per level, reset to supply-low, reset pin high
  always_comb begin
    st_d.meta = async_in; // RL16
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q <= '{meta: 3'b001, stable: 3'b001};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;

endmodule
`default_nettype wire
